// >>> logic/parallel_port_flag_pin_mux.sv
`timescale 1ns/100ps

// Overview of operation
// - 8-bit mode: strobe address latch when address bits 23..8 change.
// - 16-bit mode: strobe address latch when address bits 15..0 change.
// - shared pins carry address then data; latch strobe marks phase.
// - read strobe low for every external read.
// - write strobe low for every external write.
// - latch strobe active high after reset; software may invert it.
// - strobes stay deasserted while shared pins are flags.
// - control bit 20 with port disabled makes shared pins sixteen flags.
// - input channel 0 takes parallel data from shared pins when selected.
// - each signal pin is input or output; inputs testable.
// - as SPI master, any signal pin can drive a slave select.
// - in SPI master boot, signal pin zero is the slave select.
// - control bit 16 makes signal pin zero interrupt line 0.
// - control bit 17 makes signal pin one interrupt line 1.
// - control bit 18 makes signal pin two interrupt line 2.
// - control bit 19 makes signal pin three show timer expiry.
// - reset: read/write high, latch strobe low, signal pins three-stated.
module parallel_port_flag_pin_mux
    import par_flag_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic [CTL_W-1:0] system_control_reg_i,
    input wire logic port_enable_i,
    input wire logic wide_mode_i,
    input wire logic ale_active_low_i,
    input wire logic input_port_parallel_ctl_i,
    input wire logic spi_master_i,
    input wire logic spi_boot_i,
    input wire logic [NSIG-1:0] spi_sel_map_i,
    input wire logic spi_select_n_i,
    input wire logic sys_timer_expired_i,
    // external access requests
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [AD_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [AD_W-1:0] rdata_o,
    // shared address/data pins
    input wire logic [AD_W-1:0] par_addr_data_pins_i,
    output logic [AD_W-1:0] par_addr_data_pins_o,
    output logic [AD_W-1:0] par_addr_data_pins_oe_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic ale_o,
    // shared pins as flags
    input wire logic [AD_W-1:0] shared_flag_dir_i,
    input wire logic [AD_W-1:0] shared_flag_level_i,
    output logic [AD_W-1:0] shared_pin_flags_o,
    // input data port channel 0
    output logic [AD_W-1:0] input_data_port_o,
    output logic input_data_port_valid_o,
    // general signal pins
    input wire logic [NSIG-1:0] sig_dir_i,
    input wire logic [NSIG-1:0] sig_level_i,
    input wire logic [NSIG-1:0] general_signal_pins_i,
    output logic [NSIG-1:0] general_signal_pins_o,
    output logic [NSIG-1:0] general_signal_pins_oe_o,
    output logic [NSIG-1:0] sig_test_o,
    output logic external_interrupt_line_0_o,
    output logic external_interrupt_line_1_o,
    output logic external_interrupt_line_2_o
);

    // ========================================================
    // mode decode
    wire pins_as_flags = system_control_reg_i[BIT_PINS_AS_FLAGS] & ~port_enable_i;
    wire port_live = port_enable_i & ~pins_as_flags;
    wire idp_sel = input_port_parallel_ctl_i & ~port_enable_i & ~pins_as_flags;
    wire [NSIG-1:0] irq_sel = {1'b0, system_control_reg_i[BIT_EXTERNAL_INTERRUPT_LINE_2_SEL],
        system_control_reg_i[BIT_EXTERNAL_INTERRUPT_LINE_1_SEL], system_control_reg_i[BIT_EXTERNAL_INTERRUPT_LINE_0_SEL]};
    wire sys_timer_expired_sel = system_control_reg_i[BIT_SYS_TIMER_EXPIRED_SEL];

    // ========================================================
    // synchronised inputs
    logic [AD_W-1:0] ad_sync;
    logic [NSIG-1:0] sig_sync;

    pin_sync3 #(.W(AD_W)) u_ad_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(par_addr_data_pins_i),
        .sync_o(ad_sync)
    );

    pin_sync3 #(.W(NSIG)) u_sig_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(general_signal_pins_i),
        .sync_o(sig_sync)
    );

    // ========================================================
    // parallel port sequencer
    port_state_e state_reg;
    port_state_e state_next;
    logic [3:0] cnt_reg;
    logic [ADDR_W-1:0] last_addr_reg;
    logic write_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [AD_W-1:0] wdata_reg;

    wire take = (state_reg == ST_IDLE) & req_valid_i & port_live;
    wire hi_change = req_addr_i[ADDR_W-1:8] != last_addr_reg[ADDR_W-1:8];
    wire lo_change = req_addr_i[AD_W-1:0] != last_addr_reg[AD_W-1:0];
    wire need_ale = wide_mode_i ? lo_change : hi_change;
    wire cnt_done = cnt_reg == 4'h0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = need_ale ? ST_ADDR : ST_DATA;
                end
            end
            ST_ADDR: begin
                if (cnt_done) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (cnt_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire [3:0] cnt_load = (state_next == ST_ADDR) ? ALE_CYCLES - 4'h1 : STROBE_CYCLES - 4'h1;
    wire entering = state_next != state_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= entering ? cnt_load : (cnt_done ? 4'h0 : cnt_reg - 4'h1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_addr_reg <= ADDR_RESET;
            write_reg <= 1'b0;
            addr_reg <= ADDR_RESET;
            wdata_reg <= AD_RESET;
        end else if (take) begin
            last_addr_reg <= req_addr_i;
            write_reg <= req_write_i;
            addr_reg <= req_addr_i;
            wdata_reg <= req_wdata_i;
        end
    end

    // ========================================================
    // pin outputs: address phase then data phase
    wire in_addr = state_next == ST_ADDR;
    wire in_data = state_next == ST_DATA;
    // request registers load on the take edge, so that edge reads the request itself
    wire cur_write = take ? req_write_i : write_reg;
    wire [ADDR_W-1:0] cur_addr = take ? req_addr_i : addr_reg;
    wire [AD_W-1:0] cur_wdata = take ? req_wdata_i : wdata_reg;
    wire ale_on = in_addr & port_live;
    wire rd_on = in_data & ~cur_write & port_live;
    wire wr_on = in_data & cur_write & port_live;
    wire [AD_W-1:0] addr_phase = wide_mode_i ? cur_addr[AD_W-1:0] : cur_addr[ADDR_W-1:8];
    wire [AD_W-1:0] ad_out = pins_as_flags ? shared_flag_level_i :
        (in_addr ? addr_phase : cur_wdata);
    wire [AD_W-1:0] ad_oe = pins_as_flags ? shared_flag_dir_i :
        {AD_W{port_live & (in_addr | wr_on)}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            ale_o <= 1'b0;
            par_addr_data_pins_o <= AD_RESET;
            par_addr_data_pins_oe_o <= AD_RESET;
        end else begin
            rd_n_o <= ~rd_on;
            wr_n_o <= ~wr_on;
            ale_o <= ale_on ^ ale_active_low_i;
            par_addr_data_pins_o <= ad_out;
            par_addr_data_pins_oe_o <= ad_oe;
        end
    end

    // read data captured at the end of the strobe
    wire read_cap = (state_reg == ST_DATA) & cnt_done & ~write_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            rdata_o <= AD_RESET;
        end else begin
            req_ready_o <= state_next == ST_IDLE & port_live;
            rdata_valid_o <= read_cap;
            if (read_cap) begin
                rdata_o <= par_addr_data_pins_i;
            end
        end
    end

    // ========================================================
    // flags and input port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shared_pin_flags_o <= AD_RESET;
            input_data_port_o <= AD_RESET;
            input_data_port_valid_o <= 1'b0;
        end else begin
            shared_pin_flags_o <= pins_as_flags ? ad_sync : AD_RESET;
            input_data_port_o <= idp_sel ? ad_sync : AD_RESET;
            input_data_port_valid_o <= idp_sel;
        end
    end

    // ========================================================
    // general signal pins
    wire [NSIG-1:0] spi_drive = spi_master_i ? spi_sel_map_i : {NSIG{1'b0}};
    wire [NSIG-1:0] boot_drive = {{(NSIG-1){1'b0}}, spi_boot_i};
    wire [NSIG-1:0] sys_timer_expired_drive = {sys_timer_expired_sel, {(NSIG-1){1'b0}}};
    wire [NSIG-1:0] alt_out = spi_drive | boot_drive | sys_timer_expired_drive;
    wire [NSIG-1:0] alt_lvl;

    genvar g;
    generate
        for (g = 0; g < NSIG; g = g + 1) begin : g_sig
            assign alt_lvl[g] = sys_timer_expired_drive[g] ? sys_timer_expired_i : spi_select_n_i;
            signal_pin_cell u_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .alt_out_i(alt_out[g]),
                .alt_level_i(alt_lvl[g]),
                .alt_in_i(irq_sel[g]),
                .dir_out_i(sig_dir_i[g]),
                .level_i(sig_level_i[g]),
                .pin_o(general_signal_pins_o[g]),
                .pin_oe_o(general_signal_pins_oe_o[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig_test_o <= '0;
            external_interrupt_line_0_o <= 1'b0;
            external_interrupt_line_1_o <= 1'b0;
            external_interrupt_line_2_o <= 1'b0;
        end else begin
            sig_test_o <= sig_sync;
            external_interrupt_line_0_o <= irq_sel[0] & sig_sync[0];
            external_interrupt_line_1_o <= irq_sel[1] & sig_sync[1];
            external_interrupt_line_2_o <= irq_sel[2] & sig_sync[2];
        end
    end

    // ========================================================
    // checks
    sequence s_addr_then_data;
        ale_o != ale_active_low_i ##1 (ale_o == ale_active_low_i) ##0
            (~rd_n_o | ~wr_n_o);
    endsequence

    strobe_idle_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(pins_as_flags) & ~$past(rst_i) |->
            rd_n_o & wr_n_o & (ale_o == $past(ale_active_low_i)))
        else $error("strobe active while pins are flags");

    rd_wr_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(~rd_n_o & ~wr_n_o))
        else $error("read and write strobes together");

    read_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take & ~req_write_i & ~need_ale |=> ~rd_n_o [*2] ##1 rd_n_o)
        else $error("read strobe not two cycles");

    write_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take & req_write_i & ~need_ale |=> ~wr_n_o [*2] ##1 wr_n_o)
        else $error("write strobe not two cycles");

    ale_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take & need_ale & ~ale_active_low_i & $stable(ale_active_low_i) |=> s_addr_then_data)
        else $error("latch strobe not before data");

    wide_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take & wide_mode_i & lo_change |=> state_reg == ST_ADDR)
        else $error("no latch on low address change");

    narrow_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take & ~wide_mode_i & hi_change |=> state_reg == ST_ADDR)
        else $error("no latch on high address change");

    irq_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ~irq_sel[0] |=> ~external_interrupt_line_0_o)
        else $error("interrupt 0 without select");

    sys_timer_expired_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sys_timer_expired_sel |=> general_signal_pins_oe_o[3] &
            (general_signal_pins_o[3] == $past(sys_timer_expired_i)))
        else $error("timer expiry not on pin three");

    reset_pins_a: assert property (@(posedge clk_i)
        rst_i |=> rd_n_o & wr_n_o & ~ale_o & (general_signal_pins_oe_o == '0))
        else $error("reset pin state wrong");

endmodule

// >>> logic/par_flag_pkg.sv
package par_flag_pkg;

    // ========================================================
    // system control bit positions
    localparam int CTL_W = 32;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_0_SEL = 16;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_1_SEL = 17;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_2_SEL = 18;
    localparam int BIT_SYS_TIMER_EXPIRED_SEL = 19;
    localparam int BIT_PINS_AS_FLAGS = 20;

    // ========================================================
    // widths
    localparam int AD_W = 16;
    localparam int ADDR_W = 24;
    localparam int NSIG = 4;

    // ========================================================
    // port timing in core cycles
    localparam logic [3:0] ALE_CYCLES = 4'h1;
    localparam logic [3:0] STROBE_CYCLES = 4'h2;

    // ========================================================
    // reset values
    localparam logic [AD_W-1:0] AD_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 24'hFFFFFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_DONE = 3'b011
    } port_state_e;

endpackage

// >>> logic/pin_sync3.sv
`timescale 1ns/100ps
module pin_sync3
    import par_flag_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge clk_i) begin
        s1_reg <= async_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= '0;
        end else begin
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end

    assign sync_o = out_reg;

endmodule

// >>> logic/signal_pin_cell.sv
`timescale 1ns/100ps
module signal_pin_cell (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // selection
    input wire logic alt_out_i,
    input wire logic alt_level_i,
    input wire logic alt_in_i,
    input wire logic dir_out_i,
    input wire logic level_i,
    // pad
    output logic pin_o,
    output logic pin_oe_o
);

    wire drive = alt_out_i | (dir_out_i & ~alt_in_i);
    wire level = alt_out_i ? alt_level_i : level_i;

    // three-stated during and after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_o <= 1'b0;
            pin_o <= 1'b0;
        end else begin
            pin_oe_o <= drive;
            pin_o <= level;
        end
    end

endmodule

// >>> dv/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
    // clock
    input wire logic clk_i,
    // strobes and shared lines from the device
    input wire logic ale_active_low_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [15:0] ad_out_i,
    input wire logic [15:0] ad_oe_i,
    // level left on released lines by pull-ups or other drivers
    input wire logic [15:0] idle_i,
    // line levels seen by the device
    output logic [15:0] ad_o,
    // observation
    output int ale_cnt_o,
    output int rd_cnt_o,
    output int wr_cnt_o,
    output logic [15:0] latch_o
);
    // ========================================================
    // line levels and storage
    logic [15:0] mem [0:255];
    logic [15:0] lvl;
    logic ale_on;
    logic ale_seen = 1'b0;
    logic rd_seen = 1'b1;
    logic wr_seen = 1'b1;

    assign lvl = (ad_out_i & ad_oe_i) | (idle_i & ~ad_oe_i);
    assign ale_on = ale_i ^ ale_active_low_i;
    // memory drives the lines only while the read strobe is low
    assign ad_o = (rd_n_i === 1'b0) ? mem[latch_o[7:0]] : lvl;

    initial begin
        ale_cnt_o = 0;
        rd_cnt_o = 0;
        wr_cnt_o = 0;
        latch_o = 16'h0000;
    end

    // ========================================================
    // external latch and strobe counting
    always @(posedge clk_i) begin
        if (ale_on && !ale_seen) ale_cnt_o <= ale_cnt_o + 1;
        if (ale_on) latch_o <= lvl;
        if (!rd_n_i && rd_seen) rd_cnt_o <= rd_cnt_o + 1;
        if (!wr_n_i && wr_seen) wr_cnt_o <= wr_cnt_o + 1;
        if (!wr_n_i) mem[latch_o[7:0]] <= lvl;
        ale_seen <= ale_on;
        rd_seen <= rd_n_i;
        wr_seen <= wr_n_i;
    end
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb
    import par_flag_pkg::*;
;
    // ========================================================
    // stimulus and observation
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [CTL_W-1:0] ctl = '0;
    logic port_en = 1'b1, wide = 1'b1, ale_low = 1'b0, idp_sel = 1'b0;
    logic spi_m = 1'b0, spi_b = 1'b0, sel_n = 1'b1, tmr = 1'b0, rv = 1'b0, rw = 1'b0;
    logic [NSIG-1:0] spi_map = '0, sdir = '0, slev = '0, sext = 4'hA;
    logic [ADDR_W-1:0] ra = '0;
    logic [AD_W-1:0] wd = '0, fdir = '0, flev = '0, idle = 16'hFFFF;
    logic [AD_W-1:0] ad_in, ad_out, ad_oe, flags, input_data_port, rdata, latch;
    logic [NSIG-1:0] sig_in, sig_out, sig_oe, sig_test;
    logic ready, rvalid, rd_n, wr_n, ale, idp_v, external_interrupt_line_0, external_interrupt_line_1, external_interrupt_line_2;
    int ale_cnt, rd_cnt, wr_cnt, snap;
    int n_errors = 0;
    int compares = 0;

    assign sig_in = (sig_out & sig_oe) | (sext & ~sig_oe);
    always #12.5 clk_i = ~clk_i;

    parallel_port_flag_pin_mux dut (
        .clk_i(clk_i), .rst_i(rst_i), .system_control_reg_i(ctl), .port_enable_i(port_en),
        .wide_mode_i(wide), .ale_active_low_i(ale_low), .input_port_parallel_ctl_i(idp_sel),
        .spi_master_i(spi_m), .spi_boot_i(spi_b), .spi_sel_map_i(spi_map),
        .spi_select_n_i(sel_n), .sys_timer_expired_i(tmr), .req_valid_i(rv),
        .req_write_i(rw), .req_addr_i(ra), .req_wdata_i(wd), .req_ready_o(ready),
        .rdata_valid_o(rvalid), .rdata_o(rdata), .par_addr_data_pins_i(ad_in),
        .par_addr_data_pins_o(ad_out), .par_addr_data_pins_oe_o(ad_oe), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .ale_o(ale), .shared_flag_dir_i(fdir), .shared_flag_level_i(flev),
        .shared_pin_flags_o(flags), .input_data_port_o(input_data_port), .input_data_port_valid_o(idp_v),
        .sig_dir_i(sdir), .sig_level_i(slev), .general_signal_pins_i(sig_in),
        .general_signal_pins_o(sig_out), .general_signal_pins_oe_o(sig_oe),
        .sig_test_o(sig_test), .external_interrupt_line_0_o(external_interrupt_line_0),
        .external_interrupt_line_1_o(external_interrupt_line_1), .external_interrupt_line_2_o(external_interrupt_line_2)
    );

    ext_mem_model mem (
        .clk_i(clk_i), .ale_active_low_i(ale_low), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .ad_out_i(ad_out), .ad_oe_i(ad_oe), .idle_i(idle), .ad_o(ad_in), .ale_cnt_o(ale_cnt),
        .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt), .latch_o(latch)
    );

    // ========================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one port access; checks strobe counts, latched address and read data
    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [AD_W-1:0] d,
                       input int ale_d, input logic [AD_W-1:0] lat);
        int n;
        int a0;
        int r0;
        int w0;
        logic [AD_W-1:0] q;
        n = 0;
        q = 16'h0000;
        a0 = ale_cnt;
        r0 = rd_cnt;
        w0 = wr_cnt;
        while (ready !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 40) begin
                n_errors++;
                results();
            end
        end
        rv = 1'b1;
        rw = wr;
        ra = a;
        wd = d;
        cyc(1);
        rv = 1'b0;
        repeat (7) begin
            cyc(1);
            if (rvalid === 1'b1) q = rdata;
        end
        check(ale_cnt - a0, ale_d);
        check(wr_cnt - w0, wr);
        check(rd_cnt - r0, !wr);
        if (ale_d > 0) check(latch, lat);
        if (!wr) check(q, d);
    endtask

    // ========================================================
    // main sequence
    initial begin
        cyc(3);
        check({rd_n, wr_n, ale, sig_oe, ad_oe}, {3'b110, 4'h0, 16'h0000});
        rst_i = 1'b0;
        acc(1'b1, 24'h123456, 16'hBEEF, 1, 16'h3456);
        acc(1'b0, 24'h123456, 16'hBEEF, 0, 16'h0000);
        acc(1'b1, 24'h123457, 16'h1234, 1, 16'h3457);
        wide = 1'b0;
        acc(1'b1, 24'h567800, 16'hC0DE, 1, 16'h5678);
        acc(1'b1, 24'h5678FF, 16'h0F0F, 0, 16'h0000);
        acc(1'b0, 24'h5678FF, 16'h0F0F, 0, 16'h0000);
        wide = 1'b1;
        ale_low = 1'b1;
        cyc(2);
        check(ale, 1'b1);
        acc(1'b1, 24'h000001, 16'h5555, 1, 16'h0001);
        ale_low = 1'b0;
        port_en = 1'b0;
        ctl[BIT_PINS_AS_FLAGS] = 1'b1;
        fdir = 16'h00FF;
        flev = 16'h003C;
        idle = 16'hA5C3;
        cyc(2);
        snap = ale_cnt + rd_cnt + wr_cnt;
        rv = 1'b1;
        cyc(8);
        check(ale_cnt + rd_cnt + wr_cnt, snap);
        check({ready, rd_n, wr_n, ale}, 4'h6);
        check({ad_oe, ad_out & fdir}, {fdir, flev});
        check(flags & 16'hFF00, 16'hA500);
        rv = 1'b0;
        ctl = '0;
        fdir = '0;
        idp_sel = 1'b1;
        idle = 16'h5A69;
        cyc(8);
        check({idp_v, input_data_port}, {1'b1, 16'h5A69});
        idp_sel = 1'b0;
        port_en = 1'b1;
        sdir = 4'hF;
        slev = 4'h6;
        cyc(3);
        check({sig_oe, sig_out}, 8'hF6);
        sdir = 4'h0;
        cyc(8);
        check({sig_oe, sig_test}, 8'h0A);
        sdir = 4'hF;
        ctl[BIT_EXTERNAL_INTERRUPT_LINE_2_SEL:BIT_EXTERNAL_INTERRUPT_LINE_0_SEL] = 3'h7;
        for (int i = 0; i < 2; i++) begin
            sext = i ? 4'h5 : 4'hA;
            cyc(8);
            check(sig_oe[2:0], 3'h0);
            check(external_interrupt_line_0, sext[0]);
            check(external_interrupt_line_1, sext[1]);
            check(external_interrupt_line_2, sext[2]);
        end
        ctl = '0;
        ctl[BIT_SYS_TIMER_EXPIRED_SEL] = 1'b1;
        sdir = 4'h0;
        spi_m = 1'b1;
        spi_b = 1'b1;
        spi_map = 4'h6;
        for (int v = 0; v < 2; v++) begin
            tmr = v[0];
            sel_n = v[0];
            cyc(3);
            check({sig_oe[3], sig_out[3]}, {1'b1, v[0]});
            check({sig_oe[2:1], sig_out[2:1]}, {2'b11, {2{v[0]}}});
            check({sig_oe[0], sig_out[0]}, {1'b1, v[0]});
        end
        results();
    end
endmodule
